// File: inc/adc_regs_pkg.sv
// constants and types shared by the converter register and alert logic
//
// How it works
// - result register keeps latest result; reading it in normal mode starts a conversion
// - result register at pointer 0, read-only, resets to zero
// - bits 11:0 hold unsigned 12-bit result; bits 14:12 read zero
// - result bit 15 is one only if flag enable on and a flag set
// - over-range flag (bit 1) sets when result exceeds upper limit
// - under-range flag (bit 0) sets when result falls below lower limit
// - hold off: over-range clears when result drops below upper minus hysteresis
// - hold off: under-range clears when result rises above lower plus hysteresis
// - setup bit 4 low lets alerts self-clear beyond the hysteresis band
// - hold on: flags never self-clear; writing one to a flag clears it
// - flag register at pointer 1, resets zero, bits 7:2 read zero
// - setup bits 7:5 zero disable automatic mode, nonzero enable it
// - codes 1..7 give interval of conversion time times 32..2048
// - setup bit 3 gates result bit 15
// - setup bit 2 enables alert pin drive, otherwise pin floats
// - setup bit 0 sets alert pin active level, one is active high
// - setup register at pointer 2, resets zero, bit 1 reads zero
// - first byte of each write loads the pointer selecting later data
// - limits: lower at pointer 3 (reset 0), upper at 4 (reset fff)
package adc_regs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam int DATA_W = 16;
    localparam int RESULT_W = 12;
    localparam int PTR_W = 3;
    localparam int TIMER_W = 24;

    localparam logic [2:0] PTR_RESULT = 3'h0;
    localparam logic [2:0] PTR_FLAGS = 3'h1;
    localparam logic [2:0] PTR_SETUP = 3'h2;
    localparam logic [2:0] PTR_LOW = 3'h3;
    localparam logic [2:0] PTR_HIGH = 3'h4;
    localparam logic [2:0] PTR_HYST = 3'h5;

    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic [1:0] FLAGS_RESET = 2'h0;
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam logic [11:0] LOW_RESET = 12'h000;
    localparam logic [11:0] HIGH_RESET = 12'hfff;
    localparam logic [11:0] HYST_RESET = 12'h000;

    ////////////////////////////////////////////////////////////////////////////
    localparam int RES_ALERT_BIT = 15;
    localparam int FLAG_OVER_BIT = 1;
    localparam int FLAG_UNDER_BIT = 0;
    localparam int SETUP_CYCLE_LSB = 5;
    localparam int SETUP_HOLD_BIT = 4;
    localparam int SETUP_FLAG_EN_BIT = 3;
    localparam int SETUP_PIN_EN_BIT = 2;
    localparam int SETUP_POL_BIT = 0;
    localparam logic [7:0] SETUP_WMASK = 8'hfd;

    ////////////////////////////////////////////////////////////////////////////
    localparam int CLOCK_PERIOD_PS = 5000;
    localparam int CONV_TIME_NS = 1000;
    localparam int CONV_CYCLES = (CONV_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
    localparam int INTERVAL_SHIFT_BASE = 4;

    typedef enum logic [1:0] {
        OP_PTR,
        OP_WRITE,
        OP_READ
    } link_op_t;

    localparam int CMD_W = 2 + DATA_W;

endpackage : adc_regs_pkg

// File: sim/adc_regs_checker_assertions.sv
// port assertions for the converter register block
`timescale 1ns/1ps
module adc_regs_checker (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_link_clock,
    input wire logic i_reg_rd,
    input wire logic o_link_busy,
    input wire logic [15:0] o_rdata,
    input wire logic o_rdata_valid,
    input wire logic o_conv_start,
    input wire logic i_conv_done,
    input wire logic o_alert_out,
    input wire logic o_alert_oe
);
    //////////////////////////////////////////
    sequence s_rd_taken;
        i_reg_rd && !o_link_busy;
    endsequence
    sequence s_answer;
        ##[3:24] o_rdata_valid;
    endsequence
    a_read_answer:
        assert property (@(posedge i_link_clock) disable iff (!i_rst_n) s_rd_taken |-> s_answer)
        else $error("read gave no answer");
    a_busy_rises:
        assert property (@(posedge i_link_clock) disable iff (!i_rst_n) s_rd_taken |=> o_link_busy)
        else $error("busy missing after read");
    a_valid_pulse:
        assert property (@(posedge i_link_clock) disable iff (!i_rst_n)
            o_rdata_valid |=> !o_rdata_valid)
        else $error("read valid too long");
    a_spare_zero:
        assert property (@(posedge i_link_clock) disable iff (!i_rst_n)
            o_rdata_valid |-> o_rdata[14:12] == 3'h0)
        else $error("spare read bits set");
    //////////////////////////////////////////
    a_reset_pins:
        assert property (@(posedge i_clock) disable iff (!i_rst_n)
            $rose(i_rst_n) |-> !o_alert_oe && o_alert_out && !o_conv_start)
        else $error("pins wrong after reset");
    a_start_pulse:
        assert property (@(posedge i_clock) disable iff (!i_rst_n) o_conv_start |=> !o_conv_start)
        else $error("start pulse too long");
    a_oe_cause:
        assert property (@(posedge i_clock) disable iff (!i_rst_n)
            $changed(o_alert_oe) |-> o_link_busy || $past(o_link_busy))
        else $error("pin enable moved without write");
    a_pin_cause:
        assert property (@(posedge i_clock) disable iff (!i_rst_n)
            $changed(o_alert_out) |-> $past(i_conv_done) || o_link_busy || $past(o_link_busy))
        else $error("pin moved without result or write");
endmodule : adc_regs_checker

// File: sim/adc_result_alert_config_regs_tb_top.sv
// self-checking bench for the converter register and alert block
`timescale 1ns/1ps
module adc_result_alert_config_regs_tb_top;
    localparam int CONV_N = 2;
    localparam logic [11:0] TBL [8] = '{12'he01, 12'hdf5, 12'hdef, 12'h0ff,
        12'h110, 12'h111, 12'he00, 12'h0fe};
    localparam logic [15:0] MODES [4] = '{16'h000c, 16'h000d, 16'h0005, 16'h0008};
    logic clock = 1'b0;
    logic link_clock = 1'b0;
    logic rst_n = 1'b0;
    logic ptr_wr, reg_wr, reg_rd, link_busy, rdata_valid, conv_start, conv_done, alert_out, alert_oe;
    logic [15:0] wdata, rdata, v;
    logic [11:0] conv_result, cr;
    logic [11:0] q[$];
    int seed = 32'h566d;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    int res = 0, fo = 0, fu = 0, setup = 0, low = 0, high = 12'hfff, hyst = 0, d;
    initial
    begin
        forever #2.5 clock = ~clock;
    end
    // link clock phase unrelated to the core clock
    initial
    begin
        #7;
        forever #24 link_clock = ~link_clock;
    end
    adc_result_alert_config_regs #(.CONV_CYCLES(CONV_N)) dut (
        .i_clock(clock),
        .i_rst_n(rst_n),
        .i_link_clock(link_clock),
        .i_ptr_wr(ptr_wr),
        .i_reg_wr(reg_wr),
        .i_reg_rd(reg_rd),
        .i_wdata(wdata),
        .o_link_busy(link_busy),
        .o_rdata(rdata),
        .o_rdata_valid(rdata_valid),
        .o_conv_start(conv_start),
        .i_conv_done(conv_done),
        .i_conv_result(conv_result),
        .o_alert_out(alert_out),
        .o_alert_oe(alert_oe)
    );
    link_host_model u_host (
        .i_link_clock(link_clock),
        .i_busy(link_busy),
        .i_rdata(rdata),
        .i_rdata_valid(rdata_valid),
        .o_ptr_wr(ptr_wr),
        .o_reg_wr(reg_wr),
        .o_reg_rd(reg_rd),
        .o_wdata(wdata)
    );
    //////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim();
        n_fail += u_host.lost;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic apply(input int r);
        res = r;
        if (!setup[4] && r + hyst < high) fo = 0;
        if (!setup[4] && r > low + hyst) fu = 0;
        if (r > high) fo = 1;
        if (r < low) fu = 1;
    endtask : apply
    task automatic expect_reg(input logic [2:0] p, input logic [15:0] e);
        u_host.read_reg(p, v);
        check(v, e);
    endtask : expect_reg
    task automatic wr(input logic [2:0] p, input logic [15:0] x);
        u_host.write_reg(p, x);
        if (p == 3'h1) fo = fo & ~x[1];
        if (p == 3'h1) fu = fu & ~x[0];
        if (p == 3'h2) setup = x & 16'h00fd;
        if (p == 3'h3) low = x;
        if (p == 3'h4) high = x;
        if (p == 3'h5) hyst = x;
    endtask : wr
    task automatic pins();
        check({15'h0, alert_oe}, {15'h0, 1'(setup[2])});
        if (setup[2])
            check({15'h0, alert_out}, {15'h0, 1'(setup[0] ? fo || fu : !(fo || fu))});
    endtask : pins
    task automatic deliver(input logic [11:0] x);
        q.push_back(x);
        u_host.gap = $unsigned($random(seed)) % 3;
        expect_reg(3'h0, {1'(setup[3] && (fo || fu)), 3'h0, 12'(res)});
        check(16'(q.size()), 16'h0000);
        expect_reg(3'h1, {14'h0, 1'(fo), 1'(fu)});
        pins();
    endtask : deliver
    task automatic gap_to_start(input int lim, output int n);
        n = 0;
        do
        begin
            @(negedge clock);
            n++;
        end
        while (conv_start !== 1'b1 && n < lim);
    endtask : gap_to_start
    //////////////////////////////////////////
    // converter core: answers after a random delay, promptly or slowly
    initial
    begin
        conv_done = 1'b0;
        conv_result = 12'h000;
        forever
        begin
            @(negedge clock);
            if (conv_start === 1'b1)
            begin
                cr = (q.size() > 0) ? q.pop_front() : 12'($random(seed));
                repeat (1 + $unsigned($random(seed)) % 4) @(posedge clock);
                conv_done <= 1'b1;
                conv_result <= cr;
                @(posedge clock);
                conv_done <= 1'b0;
                conv_result <= ~cr;
                apply(cr);
            end
        end
    end
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            n_fail++;
            end_sim();
        end
    end
    initial
    begin
        // longer than 16 cycles: link reset needs three link edges
        repeat (32) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge link_clock);
        pins();
        for (int p = 0; p < 8; p++)
            expect_reg(3'(p), (p == 4) ? 16'h0fff : 16'h0000);
        $display("test reset values done");
        wr(3'h3, 16'h0100);
        wr(3'h4, 16'h0e00);
        wr(3'h5, 16'h0010);
        foreach (MODES[m])
        begin
            wr(3'h2, MODES[m]);
            foreach (TBL[i])
                deliver(TBL[i]);
            repeat (4)
                deliver(12'($random(seed)));
        end
        $display("test self-clearing alerts done");
        wr(3'h2, 16'h001f);
        expect_reg(3'h2, 16'h001d);
        deliver(12'he01);
        deliver(12'h0ff);
        deliver(12'h800);
        wr(3'h1, 16'h0002);
        expect_reg(3'h1, {14'h0, 1'(fo), 1'(fu)});
        wr(3'h1, 16'h0001);
        deliver(12'h800);
        $display("test alert hold done");
        wr(3'h3, 16'h0000);
        wr(3'h4, 16'h0fff);
        wr(3'h1, 16'h0003);
        for (int k = 1; k < 8; k++)
        begin
            wr(3'h2, 16'(k << 5));
            gap_to_start(5000, d);
            gap_to_start(5000, d);
            check(16'(d >= (CONV_N * 16 << k) && d <= (CONV_N * 16 << k) + 2), 16'h0001);
        end
        wr(3'h2, 16'h0000);
        gap_to_start(600, d);
        check(16'(d), 16'h0258);
        $display("test automatic mode done");
        end_sim();
    end
endmodule : adc_result_alert_config_regs_tb_top
bind adc_result_alert_config_regs adc_regs_checker u_chk (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_link_clock(i_link_clock),
    .i_reg_rd(i_reg_rd),
    .o_link_busy(o_link_busy),
    .o_rdata(o_rdata),
    .o_rdata_valid(o_rdata_valid),
    .o_conv_start(o_conv_start),
    .i_conv_done(i_conv_done),
    .o_alert_out(o_alert_out),
    .o_alert_oe(o_alert_oe)
);

// File: sim/link_host_model.sv
// bus controller model issuing pointer, write and read commands
`timescale 1ns/1ps
module link_host_model (
    input wire logic i_link_clock,
    input wire logic i_busy,
    input wire logic [15:0] i_rdata,
    input wire logic i_rdata_valid,
    output logic o_ptr_wr,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [15:0] o_wdata
);
    int gap = 0;
    int lost = 0;
    initial
    begin
        o_ptr_wr = 1'b0;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_wdata = 16'h5a5a;
    end
    task automatic issue(input adc_regs_pkg::link_op_t op, input logic [15:0] d);
        int n;
        n = 0;
        repeat (gap) @(posedge i_link_clock);
        @(negedge i_link_clock);
        while (i_busy !== 1'b0 && n < 100)
        begin
            @(negedge i_link_clock);
            n++;
        end
        lost += (n >= 100);
        @(posedge i_link_clock);
        o_ptr_wr <= (op == adc_regs_pkg::OP_PTR);
        o_reg_wr <= (op == adc_regs_pkg::OP_WRITE);
        o_reg_rd <= (op == adc_regs_pkg::OP_READ);
        o_wdata <= d;
        @(posedge i_link_clock);
        o_ptr_wr <= 1'b0;
        o_reg_wr <= 1'b0;
        o_reg_rd <= 1'b0;
        // released bus shows the inverse so stale data never passes
        o_wdata <= ~d;
    endtask : issue
    task automatic write_reg(input logic [2:0] p, input logic [15:0] d);
        issue(adc_regs_pkg::OP_PTR, {13'h0, p});
        if (p == adc_regs_pkg::PTR_FLAGS)
            d = d & 16'h0003;
        if (p == adc_regs_pkg::PTR_SETUP)
            d = d & 16'h00fd;
        issue(adc_regs_pkg::OP_WRITE, d);
    endtask : write_reg
    task automatic read_reg(input logic [2:0] p, output logic [15:0] d);
        int n;
        n = 0;
        issue(adc_regs_pkg::OP_PTR, {13'h0, p});
        issue(adc_regs_pkg::OP_READ, 16'h0000);
        do
        begin
            @(negedge i_link_clock);
            n++;
        end
        while (i_rdata_valid !== 1'b1 && n < 60);
        lost += (n >= 60);
        d = i_rdata;
    endtask : read_reg
endmodule : link_host_model

// File: verilog/adc_result_alert_config_regs.sv
// register file, conversion sequencing and alert logic of the converter
`timescale 1ns/1ps
module adc_result_alert_config_regs #(
    parameter int CONV_CYCLES = adc_regs_pkg::CONV_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_link_clock,
    input wire logic i_ptr_wr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] i_wdata,
    output logic o_link_busy,
    output logic [15:0] o_rdata,
    output logic o_rdata_valid,
    output logic o_conv_start,
    input wire logic i_conv_done,
    input wire logic [11:0] i_conv_result,
    output logic o_alert_out,
    output logic o_alert_oe
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [2:0] ptr;

        logic [11:0] result;
        logic [1:0] flags;
        logic [7:0] setup;

        logic [11:0] low;
        logic [11:0] high;
        logic [11:0] hyst;

        logic conv_busy;
        logic conv_pend;
        logic conv_start;

        logic rsp_valid;
        logic [15:0] rsp_data;

        logic alert_out;
        logic alert_oe;
    } core_state_t;

    typedef struct packed {
        logic rst_meta;
        logic rst_sync;
        logic [15:0] rdata;
        logic rdata_valid;
    } link_state_t;

    core_state_t core;
    core_state_t next_core;
    link_state_t link;
    link_state_t next_link;

    // command path, link side to core side
    logic cmd_valid;
    logic [adc_regs_pkg::CMD_W-1:0] cmd_word;

    logic cmd_arrived;
    logic [adc_regs_pkg::CMD_W-1:0] cmd_rx;

    // answer path, core side to link side
    logic rsp_arrived;
    logic [15:0] rsp_rx;

    logic auto_tick;

    logic link_rst_n;

    ////////////////////////////////////////////////////////////////////////////
    // read decode; min/max tracking registers are not built and read zero
    function automatic logic [15:0] reg_read(input core_state_t s);
        logic [15:0] word;
        word = 16'h0000;
        unique case (s.ptr)
            adc_regs_pkg::PTR_RESULT:
            begin
                word[11:0] = s.result;
                word[adc_regs_pkg::RES_ALERT_BIT] =
                    s.setup[adc_regs_pkg::SETUP_FLAG_EN_BIT] && (|s.flags);
            end

            adc_regs_pkg::PTR_FLAGS:
                word[1:0] = s.flags;

            adc_regs_pkg::PTR_SETUP:
                word[7:0] = s.setup;

            adc_regs_pkg::PTR_LOW:
                word[11:0] = s.low;

            adc_regs_pkg::PTR_HIGH:
                word[11:0] = s.high;
            adc_regs_pkg::PTR_HYST:
                word[11:0] = s.hyst;
            default:
                word = 16'h0000;
        endcase
        return word;
    endfunction : reg_read

    ////////////////////////////////////////////////////////////////////////////
    // link side: commands go out one at a time, busy refuses the rest
    assign link_rst_n = link.rst_sync;

    assign cmd_valid = i_ptr_wr || i_reg_wr || i_reg_rd;

    always_comb
    begin
        cmd_word = {2'(adc_regs_pkg::OP_READ), i_wdata};
        if (i_ptr_wr)
            cmd_word = {2'(adc_regs_pkg::OP_PTR), i_wdata};
        else if (i_reg_wr)
            cmd_word = {2'(adc_regs_pkg::OP_WRITE), i_wdata};
    end

    cdc_word_link #(
        .W(adc_regs_pkg::CMD_W)
    ) u_cmd_link (
        .i_src_clock(i_link_clock),
        .i_src_rst_n(link_rst_n),
        .i_src_valid(cmd_valid),
        .i_src_data(cmd_word),
        .o_src_busy(o_link_busy),
        .i_dst_clock(i_clock),
        .i_dst_rst_n(i_rst_n),
        .o_dst_valid(cmd_arrived),
        .o_dst_data(cmd_rx)
    );

    cdc_word_link #(
        .W(adc_regs_pkg::DATA_W)
    ) u_rsp_link (
        .i_src_clock(i_clock),
        .i_src_rst_n(i_rst_n),
        .i_src_valid(core.rsp_valid),
        .i_src_data(core.rsp_data),
        .o_src_busy(),
        .i_dst_clock(i_link_clock),
        .i_dst_rst_n(link_rst_n),
        .o_dst_valid(rsp_arrived),
        .o_dst_data(rsp_rx)
    );

    always_comb
    begin
        next_link = link;
        next_link.rst_meta = i_rst_n;
        next_link.rst_sync = link.rst_meta;
        next_link.rdata_valid = rsp_arrived;
        if (rsp_arrived)
            next_link.rdata = rsp_rx;
    end

    // reset is brought over by its own synchroniser, so it needs link edges
    always_ff @(posedge i_link_clock)
    begin
        if (!link.rst_sync)
        begin
            link.rst_meta <= next_link.rst_meta;
            link.rst_sync <= next_link.rst_sync;
            link.rdata <= '0;
            link.rdata_valid <= 1'b0;
        end
        else
            link <= next_link;
    end

    // read data holds until the next answer replaces it
    assign o_rdata = link.rdata;

    assign o_rdata_valid = link.rdata_valid;

    ////////////////////////////////////////////////////////////////////////////
    auto_conv_timer #(
        .CONV_CYCLES(CONV_CYCLES)
    ) u_timer (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_cycle_code(core.setup[7:5]),
        .o_tick(auto_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    logic auto_mode;
    logic hold;
    logic start_req;

    logic over_hit;
    logic over_ok;

    logic under_hit;
    logic under_ok;

    logic [1:0] flag_clear;

    logic [1:0] op_bits;

    assign auto_mode = |core.setup[7:5];

    assign hold = core.setup[adc_regs_pkg::SETUP_HOLD_BIT];

    assign op_bits = cmd_rx[adc_regs_pkg::CMD_W-1 -: 2];

    // widened by one bit so result or lower limit plus hysteresis cannot wrap
    assign over_hit = i_conv_result > core.high;

    assign under_hit = i_conv_result < core.low;

    assign over_ok = ({1'b0, i_conv_result} + {1'b0, core.hyst})
        < {1'b0, core.high};

    assign under_ok = {1'b0, i_conv_result}
        > ({1'b0, core.low} + {1'b0, core.hyst});

    always_comb
    begin
        next_core = core;
        next_core.conv_start = 1'b0;
        next_core.rsp_valid = 1'b0;
        start_req = auto_mode && auto_tick;
        flag_clear = 2'h0;

        if (cmd_arrived)
        begin
            unique case (op_bits)
                2'(adc_regs_pkg::OP_PTR):
                    next_core.ptr = cmd_rx[2:0];
                2'(adc_regs_pkg::OP_WRITE):
                begin
                    unique case (core.ptr)
                        adc_regs_pkg::PTR_FLAGS:
                            flag_clear = cmd_rx[1:0];
                        adc_regs_pkg::PTR_SETUP:
                            next_core.setup = cmd_rx[7:0] & adc_regs_pkg::SETUP_WMASK;
                        adc_regs_pkg::PTR_LOW:
                            next_core.low = cmd_rx[11:0];
                        adc_regs_pkg::PTR_HIGH:
                            next_core.high = cmd_rx[11:0];
                        adc_regs_pkg::PTR_HYST:
                            next_core.hyst = cmd_rx[11:0];
                        default:
                            next_core.ptr = core.ptr;
                    endcase
                end
                2'(adc_regs_pkg::OP_READ):
                begin
                    next_core.rsp_valid = 1'b1;
                    next_core.rsp_data = reg_read(core);
                    if (core.ptr == adc_regs_pkg::PTR_RESULT && !auto_mode)
                        start_req = 1'b1;
                end
                default:
                    next_core.rsp_valid = 1'b0;
            endcase
        end

        // flags: host clear first, then self-clear, then set, so a set wins
        next_core.flags = core.flags & ~flag_clear;
        if (i_conv_done && core.conv_busy)
        begin
            next_core.result = i_conv_result;

            if (!hold && over_ok)
                next_core.flags[adc_regs_pkg::FLAG_OVER_BIT] = 1'b0;

            if (!hold && under_ok)
                next_core.flags[adc_regs_pkg::FLAG_UNDER_BIT] = 1'b0;

            if (over_hit)
                next_core.flags[adc_regs_pkg::FLAG_OVER_BIT] = 1'b1;
            if (under_hit)
                next_core.flags[adc_regs_pkg::FLAG_UNDER_BIT] = 1'b1;
        end

        // one conversion in flight; a request that lands meanwhile waits
        if (i_conv_done && core.conv_busy)
        begin
            next_core.conv_busy = 1'b0;

            if (core.conv_pend || start_req)
            begin
                next_core.conv_pend = 1'b0;
                next_core.conv_start = 1'b1;
                next_core.conv_busy = 1'b1;
            end
        end
        else if (start_req)
        begin
            if (core.conv_busy)
                next_core.conv_pend = 1'b1;
            else
            begin
                next_core.conv_start = 1'b1;
                next_core.conv_busy = 1'b1;
            end
        end

        // pin follows the flags as they will stand, no extra cycle of lag
        next_core.alert_oe = next_core.setup[adc_regs_pkg::SETUP_PIN_EN_BIT];

        next_core.alert_out = next_core.setup[adc_regs_pkg::SETUP_POL_BIT]
            ? (|next_core.flags) : ~(|next_core.flags);
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            core <= '0;
            core.result <= adc_regs_pkg::RESULT_RESET;
            core.flags <= adc_regs_pkg::FLAGS_RESET;
            core.setup <= adc_regs_pkg::SETUP_RESET;
            core.low <= adc_regs_pkg::LOW_RESET;
            core.high <= adc_regs_pkg::HIGH_RESET;
            core.hyst <= adc_regs_pkg::HYST_RESET;
            core.alert_out <= 1'b1;
        end
        else
            core <= next_core;
    end

    ////////////////////////////////////////////////////////////////////////////
    // start and alert outputs straight from flip-flops
    assign o_conv_start = core.conv_start;

    assign o_alert_out = core.alert_out;

    assign o_alert_oe = core.alert_oe;

endmodule : adc_result_alert_config_regs

// File: verilog/auto_conv_timer.sv
// interval timer that paces automatic conversions
`timescale 1ns/1ps
module auto_conv_timer #(
    parameter int CONV_CYCLES = adc_regs_pkg::CONV_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [2:0] i_cycle_code,
    output logic o_tick
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [adc_regs_pkg::TIMER_W-1:0] count;
        logic [2:0] code_seen;
        logic tick;
    } timer_state_t;

    timer_state_t st;
    timer_state_t next_st;
    logic [adc_regs_pkg::TIMER_W-1:0] interval;

    // conversion time times 2^(code+4): 32 for code 1 up to 2048 for code 7
    assign interval = adc_regs_pkg::TIMER_W'(CONV_CYCLES)
        << (5'(i_cycle_code) + 5'(adc_regs_pkg::INTERVAL_SHIFT_BASE));

    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        next_st.code_seen = i_cycle_code;
        if (i_cycle_code == 3'h0 || i_cycle_code != st.code_seen)
            next_st.count = '0;
        else if (st.count >= interval - 1'b1)
        begin
            next_st.count = '0;
            next_st.tick = 1'b1;
        end
        else
            next_st.count = st.count + 1'b1;
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign o_tick = st.tick;

endmodule : auto_conv_timer

// File: verilog/cdc_word_link.sv
// toggle handshake that carries one word between two clock domains
`timescale 1ns/1ps
module cdc_word_link #(
    parameter int W = 16
) (
    input wire logic i_src_clock,
    input wire logic i_src_rst_n,
    input wire logic i_src_valid,
    input wire logic [W-1:0] i_src_data,
    output logic o_src_busy,
    input wire logic i_dst_clock,
    input wire logic i_dst_rst_n,
    output logic o_dst_valid,
    output logic [W-1:0] o_dst_data
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic req;
        logic [W-1:0] data;
        logic ack_meta;
        logic ack_sync;
    } src_state_t;

    typedef struct packed {
        logic req_meta;
        logic req_sync;
        logic req_seen;
        logic valid;
        logic [W-1:0] data;
    } dst_state_t;

    src_state_t src;
    src_state_t next_src;
    dst_state_t dst;
    dst_state_t next_dst;

    ////////////////////////////////////////////////////////////////////////////
    // data is held until the ack returns, so it is stable when sampled
    always_comb
    begin
        next_src = src;
        next_src.ack_meta = dst.req_seen;
        next_src.ack_sync = src.ack_meta;
        if (i_src_valid && !(src.req ^ src.ack_sync))
        begin
            next_src.req = ~src.req;
            next_src.data = i_src_data;
        end
    end

    always_ff @(posedge i_src_clock)
    begin
        if (!i_src_rst_n)
            src <= '0;
        else
            src <= next_src;
    end

    always_comb
    begin
        next_dst = dst;
        next_dst.req_meta = src.req;
        next_dst.req_sync = dst.req_meta;
        next_dst.req_seen = dst.req_sync;
        next_dst.valid = dst.req_sync ^ dst.req_seen;
        if (dst.req_sync ^ dst.req_seen)
            next_dst.data = src.data;
    end

    always_ff @(posedge i_dst_clock)
    begin
        if (!i_dst_rst_n)
            dst <= '0;
        else
            dst <= next_dst;
    end

    assign o_src_busy = src.req ^ src.ack_sync;
    assign o_dst_valid = dst.valid;
    assign o_dst_data = dst.data;

endmodule : cdc_word_link
